// ==== rtl/fbm_pkg.sv ====
/*
  Constants shared by the flash bus-mode host controller: register map, field positions,
  pin-cycle timing and flash address patterns.
  Assumes a 100 MHz ref_clk; timing counts are derived from nanosecond figures.
*/
package fbm_pkg;

  // ----------------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int ACC_NS       = 70;     // address/select to data valid
  localparam int WP_NS        = 35;     // write-enable low width
  localparam int RECOVER_NS   = 20;     // select high between cycles
  localparam int RP_NS        = 500;    // hardware reset low width
  localparam int READY_NS     = 20000;  // worst-case reset completion
  localparam int ACC_CYC      = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC       = (WP_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC  = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC       = (RP_NS * CLK_MHZ + 999) / 1000;
  localparam int READY_CYC    = (READY_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 16;

  // ----------------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int CTRL_BYTE_BIT = 0;
  localparam int CTRL_HV_BIT   = 1;
  localparam int CTRL_EXIT_BIT = 2;
  localparam int ADDR_W        = 19;
  localparam int DQ5_BIT       = 5;

  // ----------------------------------------------------------------------------
  // commands written to REG_CMD
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE      = 3'b000,
    CMD_READ      = 3'b001,
    CMD_WRITE     = 3'b010,
    CMD_HW_RESET  = 3'b011,
    CMD_ID_MAKER  = 3'b100,
    CMD_ID_PART   = 3'b101,
    CMD_ID_PROT   = 3'b110,
    CMD_RESET_CMD = 3'b111
  } fbm_cmd_type;

  typedef enum logic [1:0] {
    CYC_READ  = 2'b00,
    CYC_WRITE = 2'b01,
    CYC_RESET = 2'b10
  } fbm_cyc_op_type;

  // ----------------------------------------------------------------------------
  // flash address patterns and answer codes
  // ----------------------------------------------------------------------------
  localparam logic [17:0] ID_MAKER_LOW_ADDR  = 18'h00000;
  localparam logic [17:0] ID_MAKER_HIGH_ADDR = 18'h00100;
  localparam logic [17:0] ID_PART_ADDR       = 18'h00001;
  localparam logic [17:0] ID_PROT_ADDR       = 18'h00002;
  localparam logic [17:0] SECTOR_MASK        = 18'h3F000;
  localparam logic [7:0]  PROT_YES           = 8'h01;
  localparam logic [15:0] RESET_CMD_DATA     = 16'h00F0;
  // arbitrary value; continuation code of the attached part
  localparam logic [7:0]  CONT_CODE          = 8'hA5;

endpackage : fbm_pkg

// ==== rtl/fbm_cyc_if.sv ====
/*
  Request/answer carrier between the host sequencer and the flash pin-cycle engine.
  Assumes both ends run on ref_clk; req is a level held until the done pulse.
*/
`timescale 1ns/100ps
`default_nettype none

interface fbm_cyc_if;
  import fbm_pkg::*;
  logic           req;
  fbm_cyc_op_type op;
  logic [17:0]    addr;
  logic           low_addr;
  logic [15:0]    wdata;
  logic           hv;
  logic           byte_mode;
  logic           done;
  logic [15:0]    rdata;

  modport seq (output req, op, addr, low_addr, wdata, hv, byte_mode, input done, rdata);
  modport cyc (input req, op, addr, low_addr, wdata, hv, byte_mode, output done, rdata);
endinterface : fbm_cyc_if

`default_nettype wire

// ==== rtl/fbm_cycle.sv ====
/*
  Flash pin-cycle engine: one read, write or hardware-reset pulse per request.
  Assumes the sequencer holds req and its fields stable until done.
*/
`timescale 1ns/100ps
`default_nettype none

module fbm_cycle
  import fbm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  fbm_cyc_if.cyc           cyc,
  input  wire logic [15:0] dq_in,
  output logic [17:0]      flash_addr,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             flash_reset_n,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe,
  output logic             elevated_select_level
);

  typedef enum logic [2:0] {
    CY_IDLE     = 3'b000,
    CY_SETUP    = 3'b001,
    CY_STROBE   = 3'b010,
    CY_RECOVER  = 3'b011,
    CY_RST_LOW  = 3'b100,
    CY_RST_WAIT = 3'b101
  } fbm_cy_state_type;

  fbm_cy_state_type state;
  fbm_cy_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  fbm_cyc_op_type   op_q;
  logic             byte_q;
  logic             low_q;
  logic [15:0]      wdata_q;

  wire cnt_zero   = (cnt == '0);
  wire is_write   = (op_q == CYC_WRITE);
  wire take       = (state == CY_IDLE) && cyc.req;
  wire sample     = (state == CY_STROBE) && cnt_zero && !is_write;
  wire selecting  = (next_state == CY_SETUP) || (next_state == CY_STROBE);
  wire strobing   = (next_state == CY_STROBE);
  wire drive_data = is_write && ((next_state == CY_STROBE) || (state == CY_STROBE));

  always_comb begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - 1'b1;
    case (state)
      CY_IDLE: begin
        if (cyc.req) begin
          next_state = (cyc.op == CYC_RESET) ? CY_RST_LOW : CY_SETUP;
          next_cnt   = CNT_W'(RP_CYC - 1);
        end
      end
      CY_SETUP: begin
        next_state = CY_STROBE;
        next_cnt   = is_write ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
      end
      CY_STROBE: begin
        if (cnt_zero) begin
          next_state = CY_RECOVER;
          next_cnt   = CNT_W'(RECOVER_CYC - 1);
        end
      end
      CY_RECOVER: begin
        if (cnt_zero) begin
          next_state = CY_IDLE;
        end
      end
      CY_RST_LOW: begin
        if (cnt_zero) begin
          next_state = CY_RST_WAIT;
          next_cnt   = CNT_W'(READY_CYC - 1);
        end
      end
      CY_RST_WAIT: begin
        if (cnt_zero) begin
          next_state = CY_IDLE;
        end
      end
      default: begin
        next_state = CY_IDLE;
      end
    endcase
  end

  // done is a one-cycle pulse on the last cycle of each cycle kind
  assign cyc.done = cnt_zero && ((state == CY_RECOVER) || (state == CY_RST_WAIT));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state   <= CY_IDLE;
      cnt     <= '0;
      op_q    <= CYC_READ;
      byte_q  <= 1'b0;
      low_q   <= 1'b0;
      wdata_q <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take) begin
        op_q    <= cyc.op;
        byte_q  <= cyc.byte_mode;
        low_q   <= cyc.low_addr;
        wdata_q <= cyc.wdata;
      end
    end
  end

  // pins are registered from the next state so they change cleanly on one edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_addr            <= '0;
      ce_n                  <= 1'b1;
      oe_n                  <= 1'b1;
      we_n                  <= 1'b1;
      flash_reset_n         <= 1'b1;
      elevated_select_level <= 1'b0;
      cyc.rdata             <= '0;
    end else begin
      if (take) begin
        flash_addr <= cyc.addr;
      end
      ce_n          <= !selecting;
      oe_n          <= !(strobing && !is_write);
      we_n          <= !(strobing && is_write);
      flash_reset_n <= (next_state != CY_RST_LOW);
      // elevation only spans an id cycle, never a plain or command cycle
      elevated_select_level <= (take && cyc.hv) || (elevated_select_level && (next_state != CY_IDLE));
      if (sample) begin
        cyc.rdata <= byte_q ? {8'h00, dq_in[7:0]} : dq_in;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // data pins: in byte mode the top pin carries the low address bit from the second cycle of the first byte-mode request on
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dq
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          dq_out[gi] <= 1'b0;
          dq_oe[gi]  <= 1'b0;
        end else if (gi == 15) begin
          dq_out[gi] <= byte_q ? (take ? cyc.low_addr : low_q) : wdata_q[gi];
          dq_oe[gi]  <= (byte_q && !take) || (take && cyc.byte_mode) || (!byte_q && drive_data);
        end else begin
          dq_out[gi] <= wdata_q[gi];
          dq_oe[gi]  <= drive_data && (!byte_q || gi < 8);
        end
      end
    end
  endgenerate

endmodule : fbm_cycle

`default_nettype wire

// ==== rtl/fbm_host.sv ====
/*
  Host controller for an asynchronous parallel flash: APB register slave, operation
  sequencer and the pin-cycle engine underneath it.
  Assumes pins are synchronous to ref_clk and the board turns the elevation enable into
  the elevated level on the id pin.
*/
// Decided for this implementation: register access over APB and the address map.
// What this block does
// - host flags a reset owed after time-limit flag or in-system id; sends the reset command itself only on auto exit.
// - high-voltage id: elevate id pin, set A8 A6 A1 A0; A0 picks code.
// - protect check: sector bits high, A1 high A0 low; 01h means protected.
// - maker read with A8 low gives continuation; repeat with A8 high.
// - elevated level on id pin only for high-voltage identification.
// - in-system identification by command, no elevated level needed.
// - write: select and write enable low, output enable high.
`timescale 1ns/100ps
`default_nettype none

module fbm_host
  import fbm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe,
  output logic [17:0]      flash_addr,
  output logic             id_high_voltage_pin,
  output logic             elevated_select_level,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             flash_reset_n,
  output logic             byte_n
);

  // ----------------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE    = 3'b000,
    SQ_RUN     = 3'b001,
    SQ_ID_LOW  = 3'b010,
    SQ_ID_HIGH = 3'b011,
    SQ_EXIT    = 3'b100
  } fbm_sq_state_type;

  fbm_sq_state_type    sq_state;
  fbm_sq_state_type    next_sq_state;
  fbm_cmd_type         cmd_q;
  logic [2:0]          ctrl;
  logic [ADDR_W-1:0]   addr_reg;
  logic [15:0]         wdata_reg;
  logic [15:0]         rdata_reg;
  logic                time_limit_flag;
  logic                reset_owed;
  logic                prot_seen;
  logic                cont_seen;

  fbm_cyc_if cyc_bus ();

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  wire setup_ph   = psel && !penable;
  wire access_ph  = psel && penable;
  wire hit_ctrl   = (paddr == REG_CTRL);
  wire hit_addr   = (paddr == REG_ADDR);
  wire hit_wdata  = (paddr == REG_WDATA);
  wire hit_cmd    = (paddr == REG_CMD);
  wire hit_rdata  = (paddr == REG_RDATA);
  wire hit_status = (paddr == REG_STATUS);
  wire mapped     = hit_ctrl || hit_addr || hit_wdata || hit_cmd || hit_rdata || hit_status;
  wire busy       = (sq_state != SQ_IDLE);
  // commands are refused while busy so a running pin cycle never sees its op field move
  wire cmd_refuse = hit_cmd && pwrite && busy;
  wire wr_ok      = access_ph && pwrite && mapped && !cmd_refuse;
  wire cmd_take   = wr_ok && hit_cmd && (pwdata[2:0] != CMD_NONE);
  wire [31:0] status_word = {27'h0, cont_seen, prot_seen, reset_owed, time_limit_flag, busy};
  wire [31:0] read_mux =
      hit_ctrl   ? {29'h0, ctrl} :
      hit_addr   ? {13'h0, addr_reg} :
      hit_wdata  ? {16'h0, wdata_reg} :
      hit_rdata  ? {16'h0, rdata_reg} :
      hit_status ? status_word : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = access_ph && (!mapped || cmd_refuse);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (setup_ph) begin
      prdata <= read_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl      <= '0;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else if (wr_ok) begin
      if (hit_ctrl) ctrl <= pwdata[2:0];
      if (hit_addr) addr_reg <= pwdata[ADDR_W-1:0];
      if (hit_wdata) wdata_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------------
  // flash address forming
  // ----------------------------------------------------------------------------
  wire        byte_mode = ctrl[CTRL_BYTE_BIT];
  wire        hv_id     = ctrl[CTRL_HV_BIT];
  wire        auto_exit = ctrl[CTRL_EXIT_BIT];
  wire [17:0] word_addr = byte_mode ? addr_reg[ADDR_W-1:1] : addr_reg[17:0];
  wire        low_bit   = byte_mode && addr_reg[0];
  wire [17:0] sector_addr_bits = word_addr & SECTOR_MASK;
  wire [17:0] id_addr =
      (cmd_q == CMD_ID_PART) ? ID_PART_ADDR :
      (cmd_q == CMD_ID_PROT) ? (sector_addr_bits | ID_PROT_ADDR) :
      ID_MAKER_HIGH_ADDR;
  wire        is_id     = (sq_state == SQ_ID_LOW) || (sq_state == SQ_ID_HIGH);
  wire        cyc_done  = cyc_bus.done;
  wire        id_over   = cyc_done && (sq_state == SQ_ID_HIGH);

  assign cyc_bus.req       = busy;
  assign cyc_bus.byte_mode = byte_mode;
  assign cyc_bus.hv        = is_id && hv_id;
  assign cyc_bus.low_addr  = is_id ? 1'b0 : low_bit;
  assign cyc_bus.addr =
      (sq_state == SQ_ID_LOW)  ? ID_MAKER_LOW_ADDR :
      (sq_state == SQ_ID_HIGH) ? id_addr : word_addr;
  assign cyc_bus.wdata = (sq_state == SQ_EXIT || cmd_q == CMD_RESET_CMD) ? RESET_CMD_DATA : wdata_reg;
  assign cyc_bus.op =
      (sq_state == SQ_EXIT)                         ? CYC_WRITE :
      (sq_state != SQ_RUN)                          ? CYC_READ :
      (cmd_q == CMD_HW_RESET)                       ? CYC_RESET :
      (cmd_q == CMD_WRITE || cmd_q == CMD_RESET_CMD) ? CYC_WRITE : CYC_READ;

  // ----------------------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    next_sq_state = sq_state;
    case (sq_state)
      SQ_IDLE: begin
        if (cmd_take) begin
          case (pwdata[2:0])
            CMD_ID_MAKER: next_sq_state = SQ_ID_LOW;
            CMD_ID_PART:  next_sq_state = SQ_ID_HIGH;
            CMD_ID_PROT:  next_sq_state = SQ_ID_HIGH;
            default:      next_sq_state = SQ_RUN;
          endcase
        end
      end
      SQ_RUN: begin
        if (cyc_done) next_sq_state = SQ_IDLE;
      end
      SQ_ID_LOW: begin
        if (cyc_done) next_sq_state = SQ_ID_HIGH;
      end
      SQ_ID_HIGH: begin
        // in-system id leaves the device in id mode; optionally leave it at once
        if (cyc_done) next_sq_state = (!hv_id && auto_exit) ? SQ_EXIT : SQ_IDLE;
      end
      SQ_EXIT: begin
        if (cyc_done) next_sq_state = SQ_IDLE;
      end
      default: begin
        next_sq_state = SQ_IDLE;
      end
    endcase
  end

  wire plain_read = cyc_done && (sq_state == SQ_RUN) && (cmd_q == CMD_READ);
  wire dq5_seen   = plain_read && cyc_bus.rdata[DQ5_BIT];
  wire owe_id     = id_over && !hv_id && !auto_exit;
  wire reset_done = cyc_done && ((sq_state == SQ_EXIT) ||
                    (sq_state == SQ_RUN && (cmd_q == CMD_RESET_CMD || cmd_q == CMD_HW_RESET)));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sq_state <= SQ_IDLE;
      cmd_q    <= CMD_NONE;
    end else begin
      sq_state <= next_sq_state;
      if (cmd_take) cmd_q <= fbm_cmd_type'(pwdata[2:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg       <= '0;
      time_limit_flag <= 1'b0;
      reset_owed      <= 1'b0;
      prot_seen       <= 1'b0;
      cont_seen       <= 1'b0;
    end else begin
      if (plain_read || id_over) rdata_reg <= cyc_bus.rdata;
      if (plain_read) time_limit_flag <= dq5_seen;
      // a new cause in the same cycle as a completed reset keeps the debt standing
      reset_owed <= dq5_seen || owe_id || (reset_owed && !reset_done);
      if (id_over && cmd_q == CMD_ID_PROT) prot_seen <= (cyc_bus.rdata[7:0] == PROT_YES);
      if (cyc_done && sq_state == SQ_ID_LOW) cont_seen <= (cyc_bus.rdata[7:0] == CONT_CODE);
    end
  end

  // ----------------------------------------------------------------------------
  // pin engine
  // ----------------------------------------------------------------------------
  fbm_cycle u_cycle (
    .ref_clk               (ref_clk),
    .srst                  (srst),
    .cyc                   (cyc_bus.cyc),
    .dq_in                 (dq_in),
    .flash_addr            (flash_addr),
    .ce_n                  (ce_n),
    .oe_n                  (oe_n),
    .we_n                  (we_n),
    .flash_reset_n         (flash_reset_n),
    .dq_out                (dq_out),
    .dq_oe                 (dq_oe),
    .elevated_select_level (elevated_select_level)
  );

  assign id_high_voltage_pin = flash_addr[9];
  assign byte_n              = !byte_mode;

endmodule : fbm_host

`default_nettype wire

// ==== bench/fbm_host_assertions.sv ====
/* checker: pin-cycle properties of fbm_host.
   sees only the top ports; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module fbm_host_assertions
  import fbm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [15:0] dq_oe,
  input wire logic        id_high_voltage_pin,
  input wire logic        elevated_select_level,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        flash_reset_n,
  input wire logic        byte_n
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  a_read_pins: assert property ($fell(oe_n) |-> !ce_n && we_n && flash_reset_n)
    else $error("read strobe with wrong pins");
  a_read_width: assert property ($fell(oe_n) |-> !oe_n [*7] ##1 oe_n)
    else $error("read strobe length wrong");
  a_write_pins: assert property ($fell(we_n) |-> !ce_n && oe_n)
    else $error("write strobe with wrong pins");
  a_write_width: assert property ($fell(we_n) |-> !we_n [*4] ##1 we_n)
    else $error("write strobe length wrong");
  a_write_data: assert property (!we_n |-> dq_oe[7:0] == 8'hFF)
    else $error("write data not driven");
  a_oe_release: assert property (!oe_n |-> dq_oe[14:0] == 15'h0000)
    else $error("host drives data during read");
  a_byte_idle: assert property (!byte_n |-> dq_oe[14:8] == 7'h00)
    else $error("upper lines driven in byte mode");
  a_byte_lsb: assert property (!byte_n && !ce_n |-> dq_oe[15])
    else $error("low address bit not driven");
  a_reset_idle: assert property (!flash_reset_n |-> ce_n && oe_n && we_n)
    else $error("strobes active in reset");
  a_reset_width: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*8])
    else $error("reset pulse too short");
  a_hv_read: assert property (elevated_select_level |-> we_n && !id_high_voltage_pin)
    else $error("elevated level outside id read");
  a_standby: assert property (ce_n |-> oe_n && we_n)
    else $error("strobe without select");
  c_hv_read: cover property ($fell(oe_n) && elevated_select_level);
  c_byte_read: cover property ($fell(oe_n) && !byte_n);
  c_hw_reset: cover property ($fell(flash_reset_n));
endmodule : fbm_host_assertions

bind fbm_host fbm_host_assertions chk_u (.ref_clk, .srst, .dq_oe, .id_high_voltage_pin,
  .elevated_select_level, .ce_n, .oe_n, .we_n, .flash_reset_n, .byte_n);
`default_nettype wire

// ==== bench/fbm_flash_model.sv ====
/* behavioural flash: array reads, id codes, write latching.
   assumes the bench resolves the data bus from the host dq_oe alone. */
`timescale 1ns/100ps
`default_nettype none
module fbm_flash_model
  import fbm_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5B,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h6D   // arbitrary value
)
(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        byte_n,
  input  wire logic        hv,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq_bus,
  output logic [15:0]      dq,
  output logic [17:0]      wr_addr,
  output logic [15:0]      wr_data
);
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic        rd_on;
  logic [15:0] word;
  logic [15:0] dval;
  logic [15:0] en;
  logic [15:0] last = 16'hA55A;
  assign rd_on = !ce_n && !oe_n && reset_n;
  // no erase modelled, so every read without the elevated level is array data
  assign word = !hv ? {addr[7:0], ~addr[7:0]} :
    addr[1] ? {8'h00, 7'h00, addr[17:12] != 6'h00} :
    addr[0] ? {8'h00, PART_CODE} : {8'h00, addr[8] ? MAKER_CODE : CONT_CODE};
  assign dval = byte_n ? word : {8'h00, dq_bus[15] ? word[15:8] : word[7:0]};
  assign en = !rd_on ? 16'h0000 : byte_n ? 16'hFFFF : 16'h00FF;
  // released lines show the inverse so a stale sample cannot match
  always @* if (rd_on) last = dval;
  assign dq = (en & dval) | (~en & ~last);
  // ----------------------------------------------------------------
  // write latching
  // ----------------------------------------------------------------
  logic armed = 1'b0;
  // one process watches both strobes, so a common rise of both still latches the data once
  always @(we_n or ce_n) begin
    if (!we_n && !ce_n && oe_n && reset_n) begin
      if (!armed) wr_addr <= addr;
      armed = 1'b1;
    end else if (armed) begin
      wr_data <= dq_bus;
      armed = 1'b0;
    end
  end
endmodule : fbm_flash_model
`default_nettype wire

// ==== bench/testbench.sv ====
/* bench: apb register tasks drive fbm_host against a flash model.
   assumes a 100 MHz clock and the fbm_pkg register map. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fbm_pkg::*;
  localparam logic [7:0] MAKER = 8'h5B;  // arbitrary value
  localparam logic [7:0] PART  = 8'h6D;  // arbitrary value
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic [15:0] dq_in, dq_out, dq_oe, dq_m, wd;
  logic [17:0] flash_addr, wa;
  logic        pready, pslverr, err, idp, elev, ce_n, oe_n, we_n, frst_n, byte_n;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          i;
  always #5 ref_clk = ~ref_clk;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & dq_m);
  fbm_host dut_u (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dq_in, .dq_out, .dq_oe, .flash_addr, .id_high_voltage_pin(idp),
    .elevated_select_level(elev), .ce_n, .oe_n, .we_n, .flash_reset_n(frst_n), .byte_n);
  fbm_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.ce_n, .oe_n, .we_n,
    .reset_n(frst_n), .byte_n, .hv(elev), .addr(flash_addr), .dq_bus(dq_in), .dq(dq_m),
    .wr_addr(wa), .wr_data(wd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      give_verdict();
    end
  endtask : limit
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    limit(n, 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // writes the command, then polls busy until it clears
  task automatic run_cmd(input logic [2:0] c);
    int n;
    apb(1'b1, REG_CMD, {29'h0, c});
    for (n = 0; n < 1000; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    limit(n, 1000);
  endtask : run_cmd
  task automatic read_at(input logic [31:0] a);
    apb(1'b1, REG_ADDR, a);
    run_cmd(CMD_READ);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : read_at
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    read_at(32'h02A3C);
    check(rd, 32'h3CC3);
    apb(1'b1, REG_CTRL, 32'h1);
    for (i = 0; i < 2; i++) begin
      read_at({13'h0, 18'h02A3C, i[0]});
      check(rd, i[0] ? 32'h3C : 32'hC3);
    end
    apb(1'b1, REG_CTRL, 32'h0);
    read_at(32'h00010);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h6, 32'h6);
    run_cmd(CMD_RESET_CMD);
    check(wd, RESET_CMD_DATA);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[2], 1'b0);
    apb(1'b1, REG_ADDR, 32'h12345);
    apb(1'b1, REG_WDATA, 32'hBEEF);
    apb(1'b1, REG_CMD, {29'h0, CMD_WRITE});
    apb(1'b1, REG_CMD, {29'h0, CMD_READ});
    check(err, 1'b1);
    run_cmd(CMD_NONE);
    check(wa, 18'h12345);
    check(wd, 16'hBEEF);
    apb(1'b1, REG_CTRL, 32'h2);
    run_cmd(CMD_ID_MAKER);
    apb(1'b0, REG_RDATA, 32'h0);
    check(rd[7:0], MAKER);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[4], 1'b1);
    run_cmd(CMD_ID_PART);
    apb(1'b0, REG_RDATA, 32'h0);
    check(rd[7:0], PART);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, REG_ADDR, i[0] ? 32'h21000 : 32'h0);
      run_cmd(CMD_ID_PROT);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd[3], i[0]);
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, REG_CTRL, i[0] ? 32'h4 : 32'h0);
      run_cmd(CMD_ID_PART);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd[2], !i[0]);
    end
    check(wd, RESET_CMD_DATA);
    run_cmd(CMD_HW_RESET);
    read_at(32'h02A3C);
    check(rd, 32'h3CC3);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
